// file: rtl/dds_clock_regs.svh
`ifndef DDS_CLOCK_REGS_SVH
`define DDS_CLOCK_REGS_SVH
// ==========================================
// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_CTRL2 8'h04
`define OFF_PROF_IDX 8'h08
`define OFF_TW_LO 8'h0c
`define OFF_TW_HI 8'h10
`define OFF_DELAY 8'h14
`define OFF_STATUS 8'h18
`define OFF_PHASE 8'h1c
// ==========================================
// first control register fields
`define CTRL_RF_BYP 0
`define CTRL_RF_RATIO 1
`define CTRL_SYN_UNDIV 3
`define CTRL_DRV_SRC 4
`define CTRL_REF_EN 6
`define CTRL_FB_EN 7
`define CTRL_REF_M 8
`define CTRL_FB_N 12
`define CTRL_XTAL 16
// ==========================================
// second control register fields
`define CTRL2_CP 0
`define CTRL2_RISE 3
`define CTRL2_FALL 4
`define CTRL2_NODEF 5
`define CTRL2_RSET 6
// ==========================================
// reset values and counts
`define CTRL_RST 32'h0000_0001
`define CTRL2_RST 32'h0000_0000
`define SYNC_DIV 3'h4
`endif

// file: rtl/dds_clock_pkg.sv
package dds_clock_pkg;
   // ==========================================
   // types
   typedef logic [2:0] profile_t;
   typedef enum logic [1:0] {DRV_UNDIV, DRV_DIV, DRV_FB, DRV_SPARE} drv_src_e;
   typedef enum logic [1:0] {RF_DIV1, RF_DIV2, RF_DIV4, RF_DIV8} rf_ratio_e;
endpackage : dds_clock_pkg

// file: rtl/cosine_amp.sv
`timescale 1ns/1ps
// ==========================================
// phase to offset-binary cosine amplitude
module cosine_amp #(
   parameter int PH_W = 14,
   parameter int AMP_W = 10
) (
   input wire logic sys_clk,
   input wire logic clear,
   input wire logic tick,
   input wire logic [PH_W-1:0] phase,
   output logic [AMP_W-1:0] amp
);
   localparam int XW = PH_W - 1;
   localparam int SH = 2 * XW - 2 - (AMP_W - 1);
   localparam logic [PH_W-1:0] QUARTER = {2'b01, {(PH_W-2){1'b0}}};
   localparam logic [AMP_W-1:0] MID = {1'b1, {(AMP_W-1){1'b0}}};
   localparam logic [AMP_W-2:0] AMAX = '1;

   if (PH_W < 6 || AMP_W < 4 || SH < 0) $error("cosine_amp: unsupported widths");

   logic [AMP_W-1:0] next_amp;
   logic [PH_W-1:0] u;
   logic [XW-1:0] x;
   logic [2*XW-1:0] prod;
   logic [2*XW-1:0] scaled;
   logic [AMP_W-2:0] a;

   // parabolic half-wave: cheap, no table, a few percent shape error
   always_comb begin
      u = phase + QUARTER;
      x = u[XW-1:0];
      prod = x * (XW'(1 << (XW - 1)) * 2'(2) - x);
      scaled = prod >> SH;
      a = (scaled > (2*XW)'(AMAX)) ? AMAX : scaled[AMP_W-2:0];
      if (!u[PH_W-1]) begin
         next_amp = MID + AMP_W'(a);
      end else begin
         next_amp = MID - 1'b1 - AMP_W'(a);
      end
      if (clear) begin
         next_amp = MID;
      end else if (!tick) begin
         next_amp = amp;
      end
   end

   always_ff @(posedge sys_clk) begin
      amp <= next_amp;
   end
endmodule : cosine_amp

// file: rtl/dds_clock_divider_core.sv
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "dds_clock_regs.svh"
module dds_clock_divider_core #(
   parameter int ACC_W = 48,
   parameter int DLY_W = 14,
   parameter int AMP_W = 10
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic master_reset,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rf_clock_in,
   input wire logic feedback_clock_in,
   input wire logic reference_in,
   input wire dds_clock_pkg::profile_t profile_select,
   input wire logic io_update,
   output logic synth_clock,
   output logic output_driver_clk,
   output logic ref_div_out,
   output logic fb_div_out,
   output logic sync_clk_out,
   output logic [AMP_W-1:0] converter_out_true,
   output logic [AMP_W-1:0] converter_out_comp,
   output logic [3:0] charge_pump_mult,
   output logic surge_rise_extra,
   output logic surge_fall_extra,
   output logic surge_default_off,
   output logic internal_rset_en,
   output logic xtal_osc_en
);
   import dds_clock_pkg::*;

   localparam logic [ACC_W-1:0] TW_MAX = {1'b1, {(ACC_W-1){1'b0}}};

   if (ACC_W <= 32 || ACC_W > 64 || DLY_W < 6 || DLY_W > ACC_W || AMP_W < 4 || AMP_W > 16)
      $error("dds_clock_divider_core: unsupported widths");

   // ==========================================
   // helpers
   // divider counter: counts input rises, wraps at ratio
   function automatic logic [3:0] div_count(input logic [3:0] cnt, input logic [3:0] m1,
                                            input logic rise);
      if (!rise) begin
         div_count = cnt;
      end else if (cnt >= m1) begin
         div_count = 4'h0;
      end else begin
         div_count = cnt + 4'h1;
      end
   endfunction : div_count

   // output high for the first half of the count; ratio 1 passes the input
   function automatic logic div_level(input logic [3:0] cnt, input logic [3:0] m1,
                                      input logic in);
      logic [4:0] half;
      half = (5'(m1) + 5'h2) >> 1;
      if (m1 == 4'h0) begin
         div_level = in;
      end else begin
         div_level = 5'(cnt) < half;
      end
   endfunction : div_level

   // tuning words above half the range alias; hold them at the limit
   function automatic logic [ACC_W-1:0] clamp_tw(input logic [ACC_W-1:0] tw);
      clamp_tw = (tw > TW_MAX) ? TW_MAX : tw;
   endfunction : clamp_tw

   // ==========================================
   // state
   logic clr;
   logic [31:0] buf_ctrl, act_ctrl, buf_ctrl2, act_ctrl2;
   logic [31:0] next_buf_ctrl, next_act_ctrl, next_buf_ctrl2, next_act_ctrl2;
   logic [ACC_W-1:0] buf_tw [8];
   logic [ACC_W-1:0] act_tw [8];
   logic [DLY_W-1:0] buf_dly [8];
   logic [DLY_W-1:0] act_dly [8];
   logic [ACC_W-1:0] next_buf_tw [8];
   logic [ACC_W-1:0] next_act_tw [8];
   logic [DLY_W-1:0] next_buf_dly [8];
   logic [DLY_W-1:0] next_act_dly [8];
   logic [2:0] prof_idx, next_prof_idx;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic rf_q, fb_q, ref_q;
   logic [3:0] rf_cnt, fb_cnt, ref_cnt, next_rf_cnt, next_fb_cnt, next_ref_cnt;
   logic next_synth, next_drv, next_refo, next_fbo;
   logic [ACC_W-1:0] acc, next_acc;
   logic [1:0] sync_cnt, next_sync_cnt;
   logic next_sync_out;
   logic [AMP_W-1:0] amp;
   logic [DLY_W-1:0] phase;
   logic [3:0] rf_m1, ref_m1, fb_m1;
   logic rf_div_lvl, tick, sync_rise, wr, apb_hit;
   drv_src_e drv_sel;
   rf_ratio_e rf_sel;

   assign clr = !rst_n || master_reset;

   // ==========================================
   // clock routing and dividers
   // inputs are sampled: only valid while each is at most sys_clk / 2
   always_comb begin
      rf_sel = rf_ratio_e'(act_ctrl[`CTRL_RF_RATIO +: 2]);
      rf_m1 = act_ctrl[`CTRL_RF_BYP] ? 4'h0 : 4'((4'h1 << rf_sel) - 4'h1);
      ref_m1 = act_ctrl[`CTRL_REF_EN] ? act_ctrl[`CTRL_REF_M +: 4] : 4'h0;
      fb_m1 = act_ctrl[`CTRL_FB_EN] ? act_ctrl[`CTRL_FB_N +: 4] : 4'h0;
      next_rf_cnt = div_count(rf_cnt, rf_m1, rf_clock_in && !rf_q);
      next_ref_cnt = div_count(ref_cnt, ref_m1, reference_in && !ref_q);
      next_fb_cnt = div_count(fb_cnt, fb_m1, feedback_clock_in && !fb_q);
      rf_div_lvl = div_level(next_rf_cnt, rf_m1, rf_clock_in);
      next_refo = div_level(next_ref_cnt, ref_m1, reference_in);
      next_fbo = div_level(next_fb_cnt, fb_m1, feedback_clock_in);
      next_synth = act_ctrl[`CTRL_SYN_UNDIV] ? rf_clock_in : rf_div_lvl;
      drv_sel = drv_src_e'(act_ctrl[`CTRL_DRV_SRC +: 2]);
      case (drv_sel)
         DRV_DIV: next_drv = rf_div_lvl;
         DRV_FB: next_drv = feedback_clock_in;
         default: next_drv = rf_clock_in;
      endcase
      if (clr) begin
         next_rf_cnt = 4'h0;
         next_ref_cnt = 4'h0;
         next_fb_cnt = 4'h0;
         next_synth = 1'b0;
         next_drv = 1'b0;
         next_refo = 1'b0;
         next_fbo = 1'b0;
      end
   end

   // synthesis tick: one per rise of the routed synthesis clock
   assign tick = next_synth && !synth_clock;
   assign sync_rise = tick && sync_cnt == 2'((`SYNC_DIV / 3'h2) - 3'h1);

   always_ff @(posedge sys_clk) begin
      rf_q <= clr ? 1'b0 : rf_clock_in;
      ref_q <= clr ? 1'b0 : reference_in;
      fb_q <= clr ? 1'b0 : feedback_clock_in;
      rf_cnt <= next_rf_cnt;
      ref_cnt <= next_ref_cnt;
      fb_cnt <= next_fb_cnt;
      synth_clock <= next_synth;
      output_driver_clk <= next_drv;
      ref_div_out <= next_refo;
      fb_div_out <= next_fbo;
   end

   // ==========================================
   // synthesis core
   // delay word doubles as phase offset, so both always share one profile
   assign phase = acc[ACC_W-1 -: DLY_W] + act_dly[profile_select];

   always_comb begin
      next_acc = acc;
      next_sync_cnt = sync_cnt;
      if (tick) begin
         next_acc = acc + act_tw[profile_select];
         next_sync_cnt = sync_cnt + 2'h1;
      end
      next_sync_out = next_sync_cnt[1];
      if (clr) begin
         next_acc = '0;
         next_sync_cnt = 2'h0;
         next_sync_out = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      acc <= next_acc;
      sync_cnt <= next_sync_cnt;
      sync_clk_out <= next_sync_out;
   end

   cosine_amp #(
      .PH_W(DLY_W),
      .AMP_W(AMP_W)
   ) u_cos (
      .sys_clk(sys_clk),
      .clear(clr),
      .tick(tick),
      .phase(phase),
      .amp(amp)
   );

   // ==========================================
   // converter steering and configuration pins
   always_ff @(posedge sys_clk) begin
      converter_out_comp <= clr ? '0 : amp;
      converter_out_true <= clr ? '0 : ~amp;
      charge_pump_mult <= clr ? 4'h1 : 4'(act_ctrl2[`CTRL2_CP +: 3]) + 4'h1;
      surge_rise_extra <= !clr && act_ctrl2[`CTRL2_RISE];
      surge_fall_extra <= !clr && act_ctrl2[`CTRL2_FALL];
      surge_default_off <= !clr && act_ctrl2[`CTRL2_NODEF];
      internal_rset_en <= !clr && act_ctrl2[`CTRL2_RSET];
      xtal_osc_en <= !clr && act_ctrl[`CTRL_XTAL];
   end

   // ==========================================
   // apb slave, zero wait states
   assign wr = psel && penable && pready && pwrite;
   assign apb_hit = paddr[1:0] == 2'h0 && paddr[7:5] == 3'h0;

   always_comb begin
      next_buf_ctrl = buf_ctrl;
      next_buf_ctrl2 = buf_ctrl2;
      next_buf_tw = buf_tw;
      next_buf_dly = buf_dly;
      next_act_ctrl = act_ctrl;
      next_act_ctrl2 = act_ctrl2;
      next_act_tw = act_tw;
      next_act_dly = act_dly;
      next_prof_idx = prof_idx;
      next_pready = psel && !penable;
      next_pslverr = psel && !penable && !apb_hit;
      next_prdata = 32'h0000_0000;
      if (psel && !penable) begin
         if (paddr == `OFF_CTRL) begin
            next_prdata = buf_ctrl;
         end else if (paddr == `OFF_CTRL2) begin
            next_prdata = buf_ctrl2;
         end else if (paddr == `OFF_PROF_IDX) begin
            next_prdata = 32'(prof_idx);
         end else if (paddr == `OFF_TW_LO) begin
            next_prdata = buf_tw[prof_idx][31:0];
         end else if (paddr == `OFF_TW_HI) begin
            next_prdata = 32'(buf_tw[prof_idx][ACC_W-1:32]);
         end else if (paddr == `OFF_DELAY) begin
            next_prdata = 32'(buf_dly[prof_idx]);
         end else if (paddr == `OFF_STATUS) begin
            next_prdata = {16'h0000, 2'(amp >> (AMP_W - 2)), 9'h000, sync_clk_out,
                           1'b0, profile_select};
         end else if (paddr == `OFF_PHASE) begin
            next_prdata = acc[ACC_W-1 -: 32];
         end
      end
      if (wr) begin
         if (paddr == `OFF_CTRL) begin
            next_buf_ctrl = pwdata & 32'h0001_ffff;
         end else if (paddr == `OFF_CTRL2) begin
            next_buf_ctrl2 = pwdata & 32'h0000_007f;
         end else if (paddr == `OFF_PROF_IDX) begin
            next_prof_idx = pwdata[2:0];
         end else if (paddr == `OFF_TW_LO) begin
            next_buf_tw[prof_idx][31:0] = pwdata;
         end else if (paddr == `OFF_TW_HI) begin
            next_buf_tw[prof_idx][ACC_W-1:32] = pwdata[ACC_W-33:0];
         end else if (paddr == `OFF_DELAY) begin
            next_buf_dly[prof_idx] = pwdata[DLY_W-1:0];
         end
      end
      if (sync_rise && io_update) begin
         next_act_ctrl = buf_ctrl;
         next_act_ctrl2 = buf_ctrl2;
         for (int i = 0; i < 8; i++) begin
            next_act_tw[i] = clamp_tw(buf_tw[i]);
            next_act_dly[i] = buf_dly[i];
         end
      end
      if (clr) begin
         next_buf_ctrl = `CTRL_RST;
         next_buf_ctrl2 = `CTRL2_RST;
         next_act_ctrl = `CTRL_RST;
         next_act_ctrl2 = `CTRL2_RST;
         next_prof_idx = 3'h0;
         next_pready = 1'b0;
         next_pslverr = 1'b0;
         next_prdata = 32'h0000_0000;
         for (int i = 0; i < 8; i++) begin
            next_buf_tw[i] = '0;
            next_act_tw[i] = '0;
            next_buf_dly[i] = '0;
            next_act_dly[i] = '0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      buf_ctrl <= next_buf_ctrl;
      buf_ctrl2 <= next_buf_ctrl2;
      act_ctrl <= next_act_ctrl;
      act_ctrl2 <= next_act_ctrl2;
      buf_tw <= next_buf_tw;
      act_tw <= next_act_tw;
      buf_dly <= next_buf_dly;
      act_dly <= next_act_dly;
      prof_idx <= next_prof_idx;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
   end
endmodule : dds_clock_divider_core

// file: verification/clock_sources.sv
`timescale 1ns/1ps
// ==========================================
// far side clock sources, synchronous to sys_clk
module clock_sources #(
   parameter int FB_HALF = 3
) (
   input wire logic sys_clk,
   output logic rf_clock_in,
   output logic feedback_clock_in,
   output logic reference_in
);
   int cnt = 0;
   initial begin
      rf_clock_in = 1'b0;
      feedback_clock_in = 1'b0;
      reference_in = 1'b0;
   end
   // rf and reference at the fastest rate a sampled input can show, feedback at a sixth of sys_clk, so the limits always hold
   always @(posedge sys_clk) begin
      rf_clock_in <= ~rf_clock_in;
      reference_in <= ~reference_in;
      cnt <= (cnt == FB_HALF - 1) ? 0 : cnt + 1;
      if (cnt == FB_HALF - 1) begin
         feedback_clock_in <= ~feedback_clock_in;
      end
   end
endmodule : clock_sources

// file: verification/dds_core_monitor.sv
`timescale 1ns/1ps
// ==========================================
// port checker
module dds_core_monitor #(
   parameter int AMP_W = 10
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic master_reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sync_clk_out,
   input wire logic [AMP_W-1:0] converter_out_true,
   input wire logic [AMP_W-1:0] converter_out_comp,
   input wire logic [3:0] charge_pump_mult
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n || master_reset);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_error_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response malformed");
   a_cp_mult_range: assert property (charge_pump_mult >= 4'h1 && charge_pump_mult <= 4'h8)
      else $error("charge pump multiplier out of range");
   a_dac_complement: assert property ($past(rst_n) && !$past(master_reset) |->
      converter_out_true == ~converter_out_comp)
      else $error("converter outputs not complementary");
   a_sync_high_hold: assert property ($rose(sync_clk_out) |=> sync_clk_out [*3])
      else $error("sync clock high too short");
   a_sync_low_hold: assert property ($fell(sync_clk_out) |=> !sync_clk_out [*3])
      else $error("sync clock low too short");
   a_master_clears: assert property (disable iff (!rst_n) master_reset |=>
      charge_pump_mult == 4'h1 && converter_out_comp == '0)
      else $error("master reset did not clear");
endmodule : dds_core_monitor

bind dds_clock_divider_core dds_core_monitor #(.AMP_W(AMP_W)) chk (
   .sys_clk, .rst_n, .master_reset, .psel, .penable, .prdata, .pready, .pslverr,
   .sync_clk_out, .converter_out_true, .converter_out_comp, .charge_pump_mult
);

// file: verification/dds_clock_divider_core_test.sv
`timescale 1ns/1ps
`include "dds_clock_regs.svh"
// ==========================================
// bench
module dds_clock_divider_core_test;
   import dds_clock_pkg::*;
   typedef struct {
      logic [31:0] ctrl;
      int drv, syn, rfc, fbc;
   } row_s;
   // rises per 96 cycles: rf and reference 48, feedback 16
   row_s rows [6] = '{
      '{32'h0000_00c1, 48, 48, 48, 16},
      '{32'h0000_11da, 24, 48, 24, 8},
      '{32'h0000_3fc4, 48, 12, 3, 4},
      '{32'h0000_f7d6, 6, 6, 6, 1},
      '{32'h0001_00e1, 16, 48, 48, 16},
      '{32'h0000_ff30, 48, 48, 48, 16}
   };
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic master_reset = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, rf_clock_in, feedback_clock_in, reference_in;
   profile_t profile_select = 3'h0;
   logic io_update = 1'b0;
   logic synth_clock, output_driver_clk, ref_div_out, fb_div_out, sync_clk_out;
   logic [9:0] converter_out_true, converter_out_comp;
   logic [3:0] charge_pump_mult;
   logic surge_rise_extra, surge_fall_extra, surge_default_off, internal_rset_en, xtal_osc_en;
   logic [31:0] rd;
   logic err;
   int n [4];
   int fails = 0;
   int samples_checked = 0;

   dds_clock_divider_core uut (
      .sys_clk, .rst_n, .master_reset, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .rf_clock_in, .feedback_clock_in, .reference_in,
      .profile_select, .io_update, .synth_clock, .output_driver_clk, .ref_div_out,
      .fb_div_out, .sync_clk_out, .converter_out_true, .converter_out_comp,
      .charge_pump_mult, .surge_rise_extra, .surge_fall_extra, .surge_default_off,
      .internal_rset_en, .xtal_osc_en
   );
   clock_sources far (.sys_clk, .rf_clock_in, .feedback_clock_in, .reference_in);

   initial begin
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // counts are sampled, so phase can shift them by the tolerance
   task automatic near(input string what, input int exp, input logic [31:0] got, input int tol);
      samples_checked++;
      if ($isunknown(got) || int'(got) < exp - tol || int'(got) > exp + tol) begin
         fails++;
         $display("FAIL %s expected %0d seen %0d", what, exp, got);
      end
   endtask : near

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int t;
      @(posedge sys_clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge sys_clk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (t >= 20) begin
         fails++;
         print_verdict();
      end
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(a, 1'b0, 32'h0);
      check(what, exp, rd);
   endtask : rdchk

   // two sync rises while high, so one full tick window is covered
   task automatic update();
      int t;
      int r;
      logic s;
      io_update <= 1'b1;
      t = 0;
      r = 0;
      s = 1'b1;
      while (r < 2 && t < 400) begin
         @(posedge sys_clk);
         t++;
         if (sync_clk_out === 1'b1 && s === 1'b0) begin
            r++;
         end
         s = sync_clk_out;
      end
      io_update <= 1'b0;
      repeat (4) @(posedge sys_clk);
      if (t >= 400) begin
         fails++;
         print_verdict();
      end
   endtask : update

   task automatic measure();
      logic [3:0] p;
      logic [3:0] c;
      n = '{0, 0, 0, 0};
      p = {output_driver_clk, synth_clock, ref_div_out, fb_div_out};
      repeat (96) begin
         @(posedge sys_clk);
         c = {output_driver_clk, synth_clock, ref_div_out, fb_div_out};
         for (int i = 0; i < 4; i++) begin
            if (c[i] === 1'b1 && p[i] === 1'b0) begin
               n[3-i]++;
            end
         end
         p = c;
      end
   endtask : measure

   task automatic phase_scan(input logic [31:0] mask, input logic [31:0] all);
      logic [31:0] seen;
      seen = 32'h0;
      repeat (6) begin
         apb(`OFF_PHASE, 1'b0, 32'h0);
         check("phase step", 32'h0, rd & mask);
         seen = seen | rd;
      end
      check("phase cover", all, seen);
   endtask : phase_scan

   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      rdchk(`OFF_CTRL, `CTRL_RST, "ctrl reset");
      rdchk(`OFF_CTRL2, `CTRL2_RST, "ctrl2 reset");
      check("cp reset", 32'h1, {28'h0, charge_pump_mult});
      apb(`OFF_CTRL2, 1'b1, 32'hffff_ffff);
      rdchk(`OFF_CTRL2, 32'h0000_007f, "ctrl2 mask");
      apb(`OFF_DELAY, 1'b1, 32'hffff_ffff);
      rdchk(`OFF_DELAY, 32'h0000_3fff, "delay width");
      apb(8'h20, 1'b1, 32'hffff_ffff);
      check("unmapped err", 32'h1, {31'h0, err});
      rdchk(8'h20, 32'h0, "unmapped read");
      apb(`OFF_DELAY, 1'b1, 32'h0);
      foreach (rows[i]) begin
         apb(`OFF_CTRL, 1'b1, rows[i].ctrl);
         update();
         measure();
         near("driver", rows[i].drv, n[0], 1);
         near("synth", rows[i].syn, n[1], 1);
         near("ref div", rows[i].rfc, n[2], 1);
         near("fb div", rows[i].fbc, n[3], 1);
         check("xtal", {31'h0, rows[i].ctrl[16]}, {31'h0, xtal_osc_en});
      end
      for (int i = 0; i < 8; i++) begin
         apb(`OFF_CTRL2, 1'b1, i | ({~i[0], i[0], i[1], i[2]} << 3));
         check("cp held", 32'((i == 0) ? 8 : i), {28'h0, charge_pump_mult});
         update();
         check("cp mult", 32'(i + 1), {28'h0, charge_pump_mult});
         check("surge", {28'h0, i[2], i[1], i[0], ~i[0]}, {28'h0, surge_rise_extra,
            surge_fall_extra, surge_default_off, internal_rset_en});
      end
      // tuning words are zero here, so phase is the offset alone
      for (int i = 0; i < 3; i++) begin
         apb(`OFF_DELAY, 1'b1, 32'(i * 32'h1000));
         update();
         near("cosine", (i == 0) ? 1023 : (i == 1) ? 512 : 0,
            {22'h0, converter_out_comp}, (i == 1) ? 24 : 0);
         // quarter phase sits just below mid code, so true takes the upper half
         check("true out", 32'((i == 0) ? 0 : (i == 1) ? 512 : 1023),
            {22'h0, converter_out_true});
      end
      apb(`OFF_DELAY, 1'b1, 32'h0);
      apb(`OFF_TW_HI, 1'b1, 32'h0000_ffff);
      apb(`OFF_TW_LO, 1'b1, 32'hffff_ffff);
      apb(`OFF_PROF_IDX, 1'b1, 32'h1);
      apb(`OFF_TW_HI, 1'b1, 32'h0000_4000);
      update();
      phase_scan(32'h7fff_ffff, 32'h8000_0000);
      profile_select <= 3'h1;
      phase_scan(32'h3fff_ffff, 32'hc000_0000);
      master_reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      master_reset <= 1'b0;
      rdchk(`OFF_CTRL, `CTRL_RST, "ctrl master reset");
      rdchk(`OFF_PHASE, 32'h0, "phase master reset");
      check("cp master reset", 32'h1, {28'h0, charge_pump_mult});
      apb(`OFF_STATUS, 1'b0, 32'h0);
      check("status profile", 32'h1, rd & 32'h7);
      print_verdict();
   end
endmodule : dds_clock_divider_core_test
